// ---- core/dac_link_master.sv ----
// master end: buffers words and sends them as 16-clock frames
`timescale 1ns/1ps
`default_nettype none
`include "dac_link_consts.svh"
module dac_link_master (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    dac_link_if.master                   link,
    input  wire dac_link_pkg::word_t     wordData,
    input  wire logic                    wordValid,
    output logic                         wordReady,
    input  wire dac_link_pkg::load_mode_t loadMode,
    output logic                         busy
);
    import dac_link_pkg::*;
    typedef enum { IDLE, LEAD, SHIFT_LO, SHIFT_HI, GAP, LOAD_WAIT, LOAD_PULSE } mstate_t;
    mstate_t     state_q;
    word_t       fData;
    logic        fValid;
    logic        fReady;
    word_t       sh_q;
    logic [4:0]  bitCnt_q;
    logic [3:0]  tick_q;
    logic        csN_q;
    logic        sclk_q;
    logic        sdi_q;
    logic        ldN_q;
    logic        busy_q;
    wire         tickDone = tick_q == 4'(`SCLK_HALF_CYCLES - 1);
    // full frames only, so no resend is ever needed
    wire         lastBit  = bitCnt_q == 5'(`WORD_BITS);
    assign fReady = (state_q == IDLE);
    word_fifo #(.WIDTH(16), .DEPTH(8)) u_word_fifo (
        .core_clk (core_clk),
        .nrst     (nrst),
        .inData   (wordData),
        .inValid  (wordValid),
        .inReady  (wordReady),
        .outData  (fData),
        .outValid (fValid),
        .outReady (fReady)
    );
    assign link.csN        = csN_q;
    assign link.sclk       = sclk_q;
    assign link.sdi        = sdi_q;
    assign link.latchLoadN = ldN_q;
    assign busy            = busy_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q  <= IDLE;
            sh_q     <= '0;
            bitCnt_q <= '0;
            tick_q   <= '0;
            csN_q    <= 1'b1;
            sclk_q   <= 1'b1;
            sdi_q    <= 1'b0;
            ldN_q    <= 1'b1;
            busy_q   <= 1'b0;
        end else begin
            tick_q <= tickDone ? '0 : tick_q + 1'b1;
            // strobe stays high while selected in strobe mode, low when tied
            if (loadMode == LOAD_TIED) ldN_q <= 1'b0;
            unique case (state_q)
                IDLE: begin
                    tick_q <= '0;
                    busy_q <= fValid;
                    if (loadMode == LOAD_STROBE) ldN_q <= 1'b1;
                    if (fValid) begin
                        sh_q     <= fData;
                        csN_q    <= 1'b0;
                        bitCnt_q <= '0;
                        state_q  <= LEAD;
                    end
                end
                LEAD: if (tickDone) begin
                    sclk_q  <= 1'b0;
                    sdi_q   <= sh_q[15];
                    sh_q    <= {sh_q[14:0], 1'b0};
                    state_q <= SHIFT_LO;
                end
                // data change on falling edge, msb first; full 16 clocks
                SHIFT_LO: if (tickDone) begin
                    sclk_q   <= 1'b1;
                    bitCnt_q <= bitCnt_q + 1'b1;
                    state_q  <= SHIFT_HI;
                end
                SHIFT_HI: if (tickDone) begin
                    if (lastBit) begin
                        csN_q   <= 1'b1;
                        state_q <= GAP;
                    end else begin
                        sclk_q  <= 1'b0;
                        sdi_q   <= sh_q[15];
                        sh_q    <= {sh_q[14:0], 1'b0};
                        state_q <= SHIFT_LO;
                    end
                end
                GAP: if (tickDone) state_q <= (loadMode == LOAD_STROBE) ? LOAD_WAIT : IDLE;
                LOAD_WAIT: if (tick_q == 4'(`LOAD_DELAY_CYCLES)) begin
                    ldN_q   <= 1'b0;
                    tick_q  <= '0;
                    state_q <= LOAD_PULSE;
                end
                LOAD_PULSE: if (tick_q == 4'(`LOAD_WIDTH_CYCLES)) begin
                    ldN_q   <= 1'b1;
                    state_q <= IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- core/dac_link_consts.svh ----
// timing counts and code constants for the serial converter link
`ifndef DAC_LINK_CONSTS_SVH
`define DAC_LINK_CONSTS_SVH
`define WORD_BITS        16
`define MID_SCALE        16'h8000
`define SEG_BITS         4
`define SEG_SWITCHES     15
`define LADDER_BITS      12
`define CLK_PERIOD_NS    50
`define SCLK_HALF_CYCLES 4
`define CS_GAP_CYCLES    2
`define LOAD_WIDTH_NS    30
`define LOAD_DELAY_NS    30
`define LOAD_WIDTH_CYCLES ((`LOAD_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_DELAY_CYCLES ((`LOAD_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- core/dac_link_pkg.sv ----
// types shared by both ends of the serial converter link
package dac_link_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic { LOAD_STROBE, LOAD_TIED } load_mode_t;
endpackage

// ---- core/dac_link_if.sv ----
// serial link between the master and the converter front end
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
    logic csN;
    logic sclk;
    logic sdi;
    logic latchLoadN;
    modport master (output csN, output sclk, output sdi, output latchLoadN);
    modport converter (input csN, input sclk, input sdi, input latchLoadN);
endinterface
`default_nettype wire

// ---- core/word_fifo.sv ----
// small valid/ready word fifo
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;
    logic             ready_q;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;
    wire  [AW:0]      wrNext = push ? wrPtr_q + 1'b1 : wrPtr_q;
    wire  [AW:0]      rdNext = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    // ready registered from the next fill level
    assign inReady  = ready_q;
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData  = mem[rdPtr_q[AW-1:0]];
    always_ff @(posedge core_clk) begin
        if (push) mem[wrPtr_q[AW-1:0]] <= inData;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            ready_q <= 1'b1;
        end else begin
            wrPtr_q <= wrNext;
            rdPtr_q <= rdNext;
            ready_q <= (wrNext - rdNext) != (AW+1)'(DEPTH);
        end
    end
endmodule
`default_nettype wire

// ---- core/dac_link_converter.sv ----
// converter end: samples the serial link, holds the three word registers, decodes switches
`timescale 1ns/1ps
`default_nettype none
`include "dac_link_consts.svh"
module dac_link_converter (
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    dac_link_if.converter                 link,
    output dac_link_pkg::word_t           latchCode,
    output logic [`SEG_SWITCHES-1:0]      segment_switch_ctrl,
    output logic [`LADDER_BITS-1:0]       ladder_switch_ctrl,
    output logic                          wordLoaded
);
    import dac_link_pkg::*;
    logic [2:0] csSync_q;
    logic [2:0] sclkSync_q;
    logic [2:0] sdiSync_q;
    logic [2:0] ldSync_q;
    word_t      shift_q;
    word_t      input_q;
    word_t      latch_q;
    logic [`SEG_SWITCHES-1:0] seg_q;
    logic [`LADDER_BITS-1:0]  ladder_q;
    logic       loaded_q;
    wire  csN      = csSync_q[1];
    wire  sclkRise = sclkSync_q[1] && !sclkSync_q[2];
    wire  csRise   = csSync_q[1] && !csSync_q[2];
    wire  ldN      = ldSync_q[1];
    wire  shiftEn  = !csN && sclkRise;
    wire  word_t inputNext = csRise ? shift_q : input_q;
    wire  [`SEG_BITS-1:0] segCode = latch_q[15:12];
    logic [`SEG_SWITCHES-1:0] segNext;
    genvar gi;
    // thermometer: switch i on when code exceeds i
    generate
        for (gi = 0; gi < `SEG_SWITCHES; gi++) begin : g_therm
            assign segNext[gi] = segCode > 4'(gi);
        end
    endgenerate
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            // idle levels, so no false edge after reset
            csSync_q   <= 3'h7;
            sclkSync_q <= 3'h7;
            sdiSync_q  <= 3'h0;
            ldSync_q   <= 3'h7;
        end else begin
            csSync_q   <= {csSync_q[1:0], link.csN};
            sclkSync_q <= {sclkSync_q[1:0], link.sclk};
            sdiSync_q  <= {sdiSync_q[1:0], link.sdi};
            ldSync_q   <= {ldSync_q[1:0], link.latchLoadN};
        end
    end
    // no reset: content undefined until 16 bits shifted
    always_ff @(posedge core_clk) begin
        if (shiftEn) shift_q <= {shift_q[14:0], sdiSync_q[1]};
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            input_q  <= `MID_SCALE;
            latch_q  <= `MID_SCALE;
            seg_q    <= '0;
            ladder_q <= '0;
            loaded_q <= 1'b0;
        end else begin
            input_q  <= inputNext;
            // strobe low while deselected: latch follows input, incl. tied-low case
            if (!ldN && csN) latch_q <= inputNext;
            seg_q    <= segNext;
            ladder_q <= latch_q[11:0];
            loaded_q <= csRise;
        end
    end
    assign latchCode           = latch_q;
    assign segment_switch_ctrl = seg_q;
    assign ladder_switch_ctrl  = ladder_q;
    assign wordLoaded          = loaded_q;
endmodule
`default_nettype wire

// ---- testbench/dac_link_chk.sv ----
// link timing checks between master and converter ends
`timescale 1ns/1ps
`default_nettype none
module dac_link_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic latchLoadN
);
    logic       sclkPrev_q;
    logic [5:0] riseCnt_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sclkPrev_q <= 1'h1;
            riseCnt_q  <= 6'h0;
        end else begin
            sclkPrev_q <= sclk;
            riseCnt_q  <= csN ? 6'h0 : riseCnt_q + 6'(sclk & ~sclkPrev_q);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_strobe_held_sel: assert property (!csN && $past(latchLoadN) |-> latchLoadN)
        else $error("strobe fell while selected");
    a_strobe_after_deselect: assert property ($fell(latchLoadN) |-> csN && $past(csN))
        else $error("strobe fell too soon after deselect");
    a_data_stable_rise: assert property ($rose(sclk) && !csN |-> $stable(sdi))
        else $error("data moved at clock rise");
    a_clock_idle_high: assert property (csN |-> sclk)
        else $error("clock low while deselected");
    a_clock_low_half: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
        else $error("clock low phase wrong");
    a_select_lead: assert property ($fell(csN) |-> sclk [*4] ##1 !sclk)
        else $error("first clock fall misplaced");
    a_sixteen_rises: assert property ($rose(csN) |-> riseCnt_q == 6'h10)
        else $error("frame without sixteen clocks");
    a_deselect_gap: assert property ($rose(csN) |-> csN [*2])
        else $error("deselect gap too short");
    cover property ($rose(csN));
    cover property ($fell(latchLoadN) && csN);
    cover property (!csN && riseCnt_q == 6'h10);
endmodule
`default_nettype wire

// ---- testbench/tb_serial_dac_load_interface.sv ----
// self-checking bench for both ends of the serial converter link
`timescale 1ns/1ps
`default_nettype none
`include "dac_link_consts.svh"
module tb_serial_dac_load_interface;
    import dac_link_pkg::*;
    logic        core_clk = 1'h0;
    logic        nrst = 1'h0;
    word_t       wordData = 16'h0;
    logic        wordValid = 1'h0;
    load_mode_t  loadMode = LOAD_TIED;
    logic        sawFull = 1'h0;
    logic        wordReady, busy, wordLoaded;
    word_t       latchCode;
    logic [14:0] segCtrl;
    logic [11:0] ladderCtrl;
    int          n_mismatch = 0;
    int          n_tests = 0;
    dac_link_if link ();
    always #25 core_clk = ~core_clk;
    dac_link_master u_dac_link_master (.core_clk(core_clk), .nrst(nrst), .link(link), .wordData(wordData),
        .wordValid(wordValid), .wordReady(wordReady), .loadMode(loadMode), .busy(busy));
    dac_link_converter u_dac_link_converter (.core_clk(core_clk), .nrst(nrst), .link(link),
        .latchCode(latchCode), .segment_switch_ctrl(segCtrl), .ladder_switch_ctrl(ladderCtrl),
        .wordLoaded(wordLoaded));
    dac_link_chk u_dac_link_chk (.core_clk(core_clk), .nrst(nrst), .csN(link.csN), .sclk(link.sclk),
        .sdi(link.sdi), .latchLoadN(link.latchLoadN));
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic timeout();
        n_mismatch++;
        summarize();
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ready looked at on the falling edge, word taken at the next rising edge
    task automatic send(input word_t w);
        int i;
        @(negedge core_clk);
        wordData  = w;
        wordValid = 1'h1;
        for (i = 0; i < 2000 && wordReady !== 1'h1; i++) begin
            sawFull = 1'h1;
            @(negedge core_clk);
        end
        if (i == 2000) timeout();
        @(posedge core_clk);
        @(negedge core_clk);
        wordValid = 1'h0;
    endtask
    task automatic waitLoad();
        int i;
        for (i = 0; i < 400 && wordLoaded !== 1'h1; i++) @(negedge core_clk);
        if (i == 400) timeout();
    endtask
    task automatic settle();
        int i;
        repeat (3) @(negedge core_clk);
        for (i = 0; i < 2000 && busy !== 1'h0; i++) @(negedge core_clk);
        if (i == 2000) timeout();
        repeat (8) @(negedge core_clk);
    endtask
    task automatic chkOut(input word_t w);
        logic [14:0] t;
        for (int i = 0; i < 15; i++) t[i] = (w[15:12] > i);
        check("latch", w, latchCode);
        check("segments", {1'h0, t}, {1'h0, segCtrl});
        check("ladder", {4'h0, w[11:0]}, {4'h0, ladderCtrl});
    endtask
    initial begin
        word_t w;
        repeat (8) @(negedge core_clk);
        nrst = 1'h1;
        check("reset latch", `MID_SCALE, latchCode);
        @(negedge core_clk);
        chkOut(`MID_SCALE);
        for (int k = 0; k < 16; k++) begin
            w = {4'(k), 12'(k * 273)};
            send(w);
            waitLoad();
            check("tied latch", w, latchCode);
            settle();
            chkOut(w);
        end
        loadMode = LOAD_STROBE;
        send(16'h1234);
        waitLoad();
        check("held latch", w, latchCode);
        settle();
        chkOut(16'h1234);
        for (int k = 0; k < 10; k++) send(16'hC000 + 16'(k));
        check("fifo refused", 16'h1, {15'h0, sawFull});
        settle();
        chkOut(16'hC009);
        // second reset in mid-run, then a tied-mode word
        nrst = 1'h0;
        @(negedge core_clk);
        check("mid reset latch", `MID_SCALE, latchCode);
        nrst = 1'h1;
        @(negedge core_clk);
        chkOut(`MID_SCALE);
        loadMode = LOAD_TIED;
        send(16'h5A5A);
        waitLoad();
        check("tied after reset", 16'h5A5A, latchCode);
        settle();
        chkOut(16'h5A5A);
        summarize();
    end
endmodule
`default_nettype wire
